// [hdl/tt_three_timer.sv]
// Three timer/counters with compare/capture unit on APB.
// Assumes synchronous pins and one-cycle service acknowledges.
`timescale 1ns/1ps
module tt_three_timer (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [tt_pkg::APB_AW-1:0] paddr,
  input wire logic [tt_pkg::APB_DW-1:0] pwdata,
  output logic [tt_pkg::APB_DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Count and interrupt pins
  input wire logic countPinZero,
  input wire logic countPinOne,
  input wire logic extIrqZeroN,
  input wire logic extIrqOneN,
  input wire logic timerTwoEventPin,
  input wire logic reloadTriggerInput,
  input wire logic [3:0] captureInput,
  input wire logic irqLineTwo,
  input wire logic irqLineThree,
  // Service routine entry strobes
  input wire logic isrAckOvfZero,
  input wire logic isrAckOvfOne,
  input wire logic isrAckExtZero,
  input wire logic isrAckExtOne,
  // Status outputs
  output logic overflowFlagZero,
  output logic overflowFlagOne,
  output logic extIrqPendingZero,
  output logic extIrqPendingOne,
  output logic irqTwoEvent,
  output logic irqThreeEvent,
  output logic [3:0] compareHit
);
  import tt_pkg::*;

  function automatic logic wrHit(
    input logic en,
    input logic [7:0] idx,
    input logic [7:0] off
  );
    return en && (idx == off);
  endfunction

  // APB state
  logic pReadyFf;
  logic pSlvErrFf;
  logic [APB_DW-1:0] prdataFf;
  logic [7:0] regIdx;
  logic wrEn;
  logic [7:0] wrByte;
  logic [7:0] rdByte;
  logic mapped;

  // Registers
  logic [7:0] tconFf;
  logic [7:0] nxtTcon;
  logic [7:0] tmodFf;
  logic [7:0] ccenFf;
  logic [7:0] t2ctlFf;
  logic [15:0] t2Ff;
  logic [15:0] nxtT2;
  logic [15:0] ccFf [4];
  logic [3:0] compareHitFf;
  logic irqTwoFf;
  logic irqThreeFf;

  // Ticks and edges
  logic [3:0] divCntFf;
  logic halfFf;
  logic tick12;
  logic tick24;
  logic [E_W-1:0] pinVec;
  logic [E_W-1:0] riseEvt;
  logic [E_W-1:0] fallEvt;

  // Timer zero and one
  tt_mode_e op_field_zero;
  tt_mode_e op_field_one;
  logic run0;
  logic run1;
  logic inc0;
  logic inc1;
  logic highInc0;
  logic [7:0] t0Low;
  logic [7:0] t0High;
  logic [7:0] t1Low;
  logic [7:0] t1High;
  logic t0Wrap;
  logic t0HighWrap;
  logic t1Wrap;
  logic [3:0] flagSet;
  logic [3:0] flagAck;

  // Timer two
  tt_t2in_e t2In;
  logic t2Tick;
  logic t2Inc;
  logic t2Wrap;
  logic reloadNow;

  // APB: one wait state, data shown with pready
  assign regIdx = paddr[9:2];
  // Refused addresses must not land in any register
  assign wrEn = psel & penable & pReadyFf & pwrite & mapped;
  assign wrByte = pwdata[7:0];

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pReadyFf <= 1'b0;
      pSlvErrFf <= 1'b0;
      prdataFf <= '0;
    end else begin
      pReadyFf <= psel & penable & ~pReadyFf;
      if (psel & penable & ~pReadyFf) begin
        pSlvErrFf <= ~mapped;
        prdataFf <= pwrite ? '0 : {24'h000000, rdByte};
      end else begin
        pSlvErrFf <= 1'b0;
      end
    end
  end

  always_comb begin
    rdByte = 8'h00;
    mapped = 1'b1;
    case (regIdx)
      IDX_TCTL: rdByte = tconFf;
      IDX_TIMER01_MODE_CONFIG: rdByte = tmodFf;
      IDX_T0L: rdByte = t0Low;
      IDX_T0H: rdByte = t0High;
      IDX_T1L: rdByte = t1Low;
      IDX_T1H: rdByte = t1High;
      IDX_CAPTURE_COMPARE_ENABLE: rdByte = ccenFf;
      IDX_T2CTL: rdByte = t2ctlFf;
      IDX_T2L: rdByte = t2Ff[7:0];
      IDX_T2H: rdByte = t2Ff[15:8];
      default: mapped = 1'b0;
    endcase
    for (int c = 0; c < 4; c++) begin
      if (regIdx == CH_LOW_IDX[c]) begin
        rdByte = ccFf[c][7:0];
        mapped = 1'b1;
      end
      if (regIdx == CH_HIGH_IDX[c]) begin
        rdByte = ccFf[c][15:8];
        mapped = 1'b1;
      end
    end
    if (paddr[1:0] != 2'b00) begin
      mapped = 1'b0;
      rdByte = 8'h00;
    end
  end

  // Configuration registers
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      tmodFf <= TIMER01_MODE_CONFIG_RST;
      ccenFf <= CAPTURE_COMPARE_ENABLE_RST;
      t2ctlFf <= T2CTL_RST;
    end else begin
      if (wrHit(wrEn, regIdx, IDX_TIMER01_MODE_CONFIG)) begin
        tmodFf <= wrByte;
      end
      if (wrHit(wrEn, regIdx, IDX_CAPTURE_COMPARE_ENABLE)) begin
        ccenFf <= wrByte;
      end
      if (wrHit(wrEn, regIdx, IDX_T2CTL)) begin
        t2ctlFf <= wrByte;
      end
    end
  end

  // Tick prescaler shared by all timers
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      divCntFf <= 4'h0;
      halfFf <= 1'b0;
    end else begin
      divCntFf <= tick12 ? 4'h0 : divCntFf + 4'h1;
      if (tick12) begin
        halfFf <= ~halfFf;
      end
    end
  end

  assign tick12 = (divCntFf == TICK_DIV - 4'h1);
  assign tick24 = tick12 & halfFf;

  assign pinVec = {captureInput, irqLineThree, irqLineTwo, reloadTriggerInput,
                   timerTwoEventPin, extIrqOneN, extIrqZeroN, countPinOne, countPinZero};

  tt_edge_det #(.W(E_W)) u_edges (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .sigIn(pinVec),
    .riseEvt(riseEvt),
    .fallEvt(fallEvt)
  );

  // Timers zero and one
  assign op_field_zero = tt_mode_e'(tmodFf[OP_FIELD_ZERO_LSB +: 2]);
  assign op_field_one = tt_mode_e'(tmodFf[OP_FIELD_ONE_LSB +: 2]);
  assign run0 = tconFf[TR0] & (~tmodFf[GATING_BIT_ZERO] | extIrqZeroN);
  assign run1 = tconFf[TR1] & (~tmodFf[GATING_BIT_ONE] | extIrqOneN);
  assign inc0 = run0 & (tmodFf[CT0] ? fallEvt[E_T0] : tick12);
  assign inc1 = run1 & (tmodFf[CT1] ? fallEvt[E_T1] : tick12) & (op_field_one != MODE_SPLIT);
  // Split high half borrows timer one's run bit
  assign highInc0 = tconFf[TR1] & tick12;

  tt_timer_core u_timer0 (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .mode(op_field_zero),
    .lowInc(inc0),
    .highInc(highInc0),
    .wrLow(wrHit(wrEn, regIdx, IDX_T0L)),
    .wrHigh(wrHit(wrEn, regIdx, IDX_T0H)),
    .wrData(wrByte),
    .countLow(t0Low),
    .countHigh(t0High),
    .mainWrap(t0Wrap),
    .highWrap(t0HighWrap)
  );

  tt_timer_core u_timer1 (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .mode(op_field_one),
    .lowInc(inc1),
    .highInc(1'b0),
    .wrLow(wrHit(wrEn, regIdx, IDX_T1L)),
    .wrHigh(wrHit(wrEn, regIdx, IDX_T1H)),
    .wrData(wrByte),
    .countLow(t1Low),
    .countHigh(t1High),
    .mainWrap(t1Wrap),
    .highWrap()
  );

  // Flag order: overflow one, overflow zero, ext one, ext zero
  assign flagSet[3] = t1Wrap | ((op_field_zero == MODE_SPLIT) & t0HighWrap);
  assign flagSet[2] = t0Wrap;
  assign flagSet[1] = tconFf[IT1] ? fallEvt[E_X1] : ~extIrqOneN;
  assign flagSet[0] = tconFf[IT0] ? fallEvt[E_X0] : ~extIrqZeroN;
  assign flagAck = {isrAckOvfOne, isrAckOvfZero, isrAckExtOne, isrAckExtZero};

  // Hardware set wins over service clear and software write
  always_comb begin
    nxtTcon = tconFf;
    if (wrHit(wrEn, regIdx, IDX_TCTL)) begin
      nxtTcon = wrByte;
    end
    for (int f = 0; f < 4; f++) begin
      if (flagAck[f]) begin
        nxtTcon[2 * f + 1] = 1'b0;
      end
      if (flagSet[f]) begin
        nxtTcon[2 * f + 1] = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      tconFf <= TCTL_RST;
    end else begin
      tconFf <= nxtTcon;
    end
  end

  // Timer two
  assign t2In = tt_t2in_e'(t2ctlFf[T2_IN_LSB +: 2]);
  assign t2Tick = t2ctlFf[T2_PS] ? tick24 : tick12;

  always_comb begin
    unique case (t2In)
      T2_STOP: t2Inc = 1'b0;
      T2_TICK: t2Inc = t2Tick;
      T2_EVENT: t2Inc = fallEvt[E_T2];
      T2_GATED: t2Inc = t2Tick & timerTwoEventPin;
    endcase
  end

  assign t2Wrap = t2Inc & (t2Ff == 16'hffff);
  // Top bit clear leaves reload off
  assign reloadNow = ((t2ctlFf[T2_RLD_LSB +: 2] == RLD_OVF) & t2Wrap) |
                     ((t2ctlFf[T2_RLD_LSB +: 2] == RLD_EXT) & fallEvt[E_RT]);

  always_comb begin
    nxtT2 = t2Ff;
    if (reloadNow) begin
      nxtT2 = ccFf[0];
    end else if (t2Inc) begin
      nxtT2 = t2Ff + 16'h0001;
    end
    if (wrHit(wrEn, regIdx, IDX_T2L)) begin
      nxtT2[7:0] = wrByte;
    end
    if (wrHit(wrEn, regIdx, IDX_T2H)) begin
      nxtT2[15:8] = wrByte;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      t2Ff <= {COUNT_RST, COUNT_RST};
    end else begin
      t2Ff <= nxtT2;
    end
  end

  // Compare/capture channels
  genvar ch;
  generate
    for (ch = 0; ch < 4; ch++) begin : g_chan
      tt_ch_e chMode;
      logic wrLow;
      logic wrHigh;
      logic capNow;

      assign chMode = tt_ch_e'(ccenFf[2 * ch +: 2]);
      assign wrLow = wrHit(wrEn, regIdx, CH_LOW_IDX[ch]);
      assign wrHigh = wrHit(wrEn, regIdx, CH_HIGH_IDX[ch]);
      assign capNow = ((chMode == CH_CAP_EDGE) & riseEvt[E_CAP0 + 3 - ch]) |
                      ((chMode == CH_CAP_WRITE) & wrLow);

      // Capture takes the timer value over the written byte
      always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
          ccFf[ch] <= 16'h0000;
        end else if (capNow) begin
          ccFf[ch] <= t2Ff;
        end else begin
          if (wrLow) begin
            ccFf[ch][7:0] <= wrByte;
          end
          if (wrHigh) begin
            ccFf[ch][15:8] <= wrByte;
          end
        end
      end

      always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
          compareHitFf[ch] <= 1'b0;
        end else begin
          compareHitFf[ch] <= (chMode == CH_COMPARE) & (t2Ff == ccFf[ch]);
        end
      end
    end
  endgenerate

  // Interrupt two and three edge events
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      irqTwoFf <= 1'b0;
      irqThreeFf <= 1'b0;
    end else begin
      irqTwoFf <= t2ctlFf[T2_I2] ? riseEvt[E_I2] : fallEvt[E_I2];
      irqThreeFf <= t2ctlFf[T2_I3] ? riseEvt[E_I3] : fallEvt[E_I3];
    end
  end

  assign prdata = prdataFf;
  assign pready = pReadyFf;
  assign pslverr = pSlvErrFf;
  assign overflowFlagOne = tconFf[TF1];
  assign overflowFlagZero = tconFf[TF0];
  assign extIrqPendingOne = tconFf[IE1];
  assign extIrqPendingZero = tconFf[IE0];
  assign irqTwoEvent = irqTwoFf;
  assign irqThreeEvent = irqThreeFf;
  assign compareHit = compareHitFf;
endmodule

// [hdl/tt_pkg.sv]
// Constants and types shared by the three-timer block.
// Assumes a 40 MHz ref_clk and APB register access.
package tt_pkg;

  localparam int APB_AW = 10;
  localparam int APB_DW = 32;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_TCTL = 8'h88;
  localparam logic [7:0] IDX_TIMER01_MODE_CONFIG = 8'h89;
  localparam logic [7:0] IDX_T0L = 8'h8a;
  localparam logic [7:0] IDX_T1L = 8'h8b;
  localparam logic [7:0] IDX_T0H = 8'h8c;
  localparam logic [7:0] IDX_T1H = 8'h8d;
  localparam logic [7:0] IDX_CAPTURE_COMPARE_ENABLE = 8'hc1;
  localparam logic [7:0] IDX_T2CTL = 8'hc8;
  localparam logic [7:0] IDX_T2L = 8'hcc;
  localparam logic [7:0] IDX_T2H = 8'hcd;
  // Channel 0 is the compare/reload/capture register
  localparam logic [7:0] CH_LOW_IDX [4] = '{8'hca, 8'hc2, 8'hc4, 8'hc6};
  localparam logic [7:0] CH_HIGH_IDX [4] = '{8'hcb, 8'hc3, 8'hc5, 8'hc7};

  // Reset values
  localparam logic [7:0] TCTL_RST = 8'h00;
  localparam logic [7:0] TIMER01_MODE_CONFIG_RST = 8'h00;
  localparam logic [7:0] CAPTURE_COMPARE_ENABLE_RST = 8'h00;
  localparam logic [7:0] T2CTL_RST = 8'h00;
  localparam logic [7:0] COUNT_RST = 8'h00;

  // Shared control/status fields
  localparam int TF1 = 7;
  localparam int TR1 = 6;
  localparam int TF0 = 5;
  localparam int TR0 = 4;
  localparam int IE1 = 3;
  localparam int IT1 = 2;
  localparam int IE0 = 1;
  localparam int IT0 = 0;

  // Mode register fields
  localparam int GATING_BIT_ONE = 7;
  localparam int CT1 = 6;
  localparam int OP_FIELD_ONE_LSB = 4;
  localparam int GATING_BIT_ZERO = 3;
  localparam int CT0 = 2;
  localparam int OP_FIELD_ZERO_LSB = 0;

  // Timer-two control fields
  localparam int T2_PS = 7;
  localparam int T2_I3 = 6;
  localparam int T2_I2 = 5;
  localparam int T2_RLD_LSB = 3;
  localparam int T2_CM = 2;
  localparam int T2_IN_LSB = 0;

  // Edge-detector lanes
  localparam int E_T0 = 0;
  localparam int E_T1 = 1;
  localparam int E_X0 = 2;
  localparam int E_X1 = 3;
  localparam int E_T2 = 4;
  localparam int E_RT = 5;
  localparam int E_I2 = 6;
  localparam int E_I3 = 7;
  localparam int E_CAP0 = 8;
  localparam int E_W = 12;

  // Tick divider
  localparam logic [3:0] TICK_DIV = 4'hc;

  typedef enum logic [1:0] {
    MODE_13BIT = 2'b00, MODE_16BIT = 2'b01, MODE_RELOAD8 = 2'b10, MODE_SPLIT = 2'b11
  } tt_mode_e;

  typedef enum logic [1:0] {
    T2_STOP = 2'b00, T2_TICK = 2'b01, T2_EVENT = 2'b10, T2_GATED = 2'b11
  } tt_t2in_e;

  typedef enum logic [1:0] {
    CH_OFF = 2'b00, CH_CAP_EDGE = 2'b01, CH_COMPARE = 2'b10, CH_CAP_WRITE = 2'b11
  } tt_ch_e;

  localparam logic [1:0] RLD_OVF = 2'b10;
  localparam logic [1:0] RLD_EXT = 2'b11;

endpackage

// [hdl/tt_edge_det.sv]
// Rise and fall detector over a vector of synchronous inputs.
// Assumes inputs already synchronous to ref_clk.
`timescale 1ns/1ps
module tt_edge_det #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Sampled inputs and edge pulses
  input wire logic [W-1:0] sigIn,
  output logic [W-1:0] riseEvt,
  output logic [W-1:0] fallEvt
);
  logic [W-1:0] prevFf;

  // Idle-high start avoids a false rise on active-low pins
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      prevFf <= '1;
    end else begin
      prevFf <= sigIn;
    end
  end

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_lane
      assign riseEvt[i] = sigIn[i] & ~prevFf[i];
      assign fallEvt[i] = ~sigIn[i] & prevFf[i];
    end
  endgenerate
endmodule

// [hdl/tt_timer_core.sv]
// Count pair of timer zero or one, with four modes.
// Assumes increments arrive as single-cycle strobes.
`timescale 1ns/1ps
module tt_timer_core (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Control
  input tt_pkg::tt_mode_e mode,
  input wire logic lowInc,
  input wire logic highInc,
  // Software access
  input wire logic wrLow,
  input wire logic wrHigh,
  input wire logic [7:0] wrData,
  // Count and wrap strobes
  output logic [7:0] countLow,
  output logic [7:0] countHigh,
  output logic mainWrap,
  output logic highWrap
);
  import tt_pkg::*;

  logic [7:0] lowFf;
  logic [7:0] highFf;
  logic [7:0] nxtLow;
  logic [7:0] nxtHigh;

  always_comb begin
    nxtLow = lowFf;
    nxtHigh = highFf;
    mainWrap = 1'b0;
    highWrap = 1'b0;
    unique case (mode)
      MODE_13BIT: begin
        if (lowInc) begin
          nxtLow = {lowFf[7:5], lowFf[4:0] + 5'h01};
          if (lowFf[4:0] == 5'h1f) begin
            nxtHigh = highFf + 8'h01;
            mainWrap = (highFf == 8'hff);
          end
        end
      end
      MODE_16BIT: begin
        if (lowInc) begin
          nxtLow = lowFf + 8'h01;
          if (lowFf == 8'hff) begin
            nxtHigh = highFf + 8'h01;
            mainWrap = (highFf == 8'hff);
          end
        end
      end
      MODE_RELOAD8: begin
        if (lowInc) begin
          if (lowFf == 8'hff) begin
            nxtLow = highFf;
            mainWrap = 1'b1;
          end else begin
            nxtLow = lowFf + 8'h01;
          end
        end
      end
      MODE_SPLIT: begin
        if (lowInc) begin
          nxtLow = lowFf + 8'h01;
          mainWrap = (lowFf == 8'hff);
        end
        if (highInc) begin
          nxtHigh = highFf + 8'h01;
          highWrap = (highFf == 8'hff);
        end
      end
    endcase
    // Software write wins over a same-cycle count
    if (wrLow) begin
      nxtLow = wrData;
    end
    if (wrHigh) begin
      nxtHigh = wrData;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      lowFf <= COUNT_RST;
      highFf <= COUNT_RST;
    end else begin
      lowFf <= nxtLow;
      highFf <= nxtHigh;
    end
  end

  assign countLow = lowFf;
  assign countHigh = highFf;
endmodule

// [tb/tt_three_timer_monitor.sv]
// Port-level checks on the three-timer block.
// Assumes it is bound into tt_three_timer; one clock domain.
`timescale 1ns/1ps
module tt_three_timer_monitor (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [tt_pkg::APB_AW-1:0] paddr,
  input wire logic [tt_pkg::APB_DW-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins and status
  input wire logic extIrqZeroN,
  input wire logic irqLineTwo,
  input wire logic irqLineThree,
  input wire logic isrAckOvfZero,
  input wire logic isrAckOvfOne,
  input wire logic overflowFlagZero,
  input wire logic overflowFlagOne,
  input wire logic extIrqPendingZero,
  input wire logic irqTwoEvent,
  input wire logic irqThreeEvent,
  input wire logic [3:0] compareHit
);
  import tt_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  a_ready_single: assert property (pready |=> !pready)
    else $error("pready held beyond one cycle");
  a_ready_wait: assert property (psel && $rose(penable) |=> pready)
    else $error("pready missing after one wait state");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  a_misalign_err: assert property (pready && paddr[1:0] != 2'b00 |-> pslverr)
    else $error("misaligned access not refused");
  a_ovf0_clear: assert property ($fell(overflowFlagZero) |-> $past(isrAckOvfZero) || $past(pwrite && pready))
    else $error("timer zero flag cleared without cause");
  a_ovf1_clear: assert property ($fell(overflowFlagOne) |-> $past(isrAckOvfOne) || $past(pwrite && pready))
    else $error("timer one flag cleared without cause");
  a_pend_cause: assert property ($rose(extIrqPendingZero)
    |-> !$past(extIrqZeroN) || !$past(extIrqZeroN, 2) || $past(pwrite && pready))
    else $error("pending bit set without low pin");
  a_irq2_edge: assert property (irqTwoEvent
    |-> $past(irqLineTwo) != $past(irqLineTwo, 2) || $past(irqLineTwo, 2) != $past(irqLineTwo, 3))
    else $error("irq two event without edge");
  a_irq3_edge: assert property (irqThreeEvent
    |-> $past(irqLineThree) != $past(irqLineThree, 2) || $past(irqLineThree, 2) != $past(irqLineThree, 3))
    else $error("irq three event without edge");
  c_refused: cover property (pslverr);
  c_ovf_one: cover property ($rose(overflowFlagOne));
  c_compare: cover property (compareHit[3]);
  c_irq3: cover property (irqThreeEvent);
endmodule
bind tt_three_timer tt_three_timer_monitor u_tt_three_timer_monitor (.ref_clk, .reset_n, .psel, .penable,
  .pwrite, .paddr, .prdata, .pready, .pslverr, .extIrqZeroN, .irqLineTwo, .irqLineThree, .isrAckOvfZero,
  .isrAckOvfOne, .overflowFlagZero, .overflowFlagOne, .extIrqPendingZero, .irqTwoEvent, .irqThreeEvent,
  .compareHit);

// [tb/tt_testbench.sv]
// Self-checking bench for the three-timer block.
// Assumes APB answers with one wait state; pins idle high, capture inputs idle low.
`timescale 1ns/1ps
`define CHK(a, b) begin cmpCount++; if ((a) !== (b)) begin errors++; $display("[FAIL] %0t %h %h", $time, a, b); end end
module testbench;
  import tt_pkg::*;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [APB_AW-1:0] paddr = '0;
  logic [APB_DW-1:0] pwdata = '0;
  logic [APB_DW-1:0] prdata;
  logic pready, pslverr, ovf0, ovf1, pnd0, pnd1, ev2, ev3;
  logic [3:0] hit;
  // Pin lanes: cnt0 cnt1 t2ev reload ext0N ext1N irq2 irq3
  logic [7:0] pv = 8'hff;
  logic [3:0] cap = 4'h0;
  logic [3:0] ak = 4'h0;
  logic [1:0] mis = 2'b00;
  int errors = 0;
  int cmpCount = 0;
  int n2 = 0;
  int n3 = 0;

  tt_three_timer u_tt_three_timer (.ref_clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .countPinZero(pv[0]), .countPinOne(pv[1]), .extIrqZeroN(pv[4]), .extIrqOneN(pv[5]),
    .timerTwoEventPin(pv[2]), .reloadTriggerInput(pv[3]), .captureInput(cap), .irqLineTwo(pv[6]),
    .irqLineThree(pv[7]), .isrAckOvfZero(ak[0]), .isrAckOvfOne(ak[1]), .isrAckExtZero(ak[2]),
    .isrAckExtOne(ak[3]), .overflowFlagZero(ovf0), .overflowFlagOne(ovf1), .extIrqPendingZero(pnd0),
    .extIrqPendingOne(pnd1), .irqTwoEvent(ev2), .irqThreeEvent(ev3), .compareHit(hit));

  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    if (ev2 === 1'b1) n2++;
    if (ev3 === 1'b1) n3++;
  end

  // Values read at the edge are the pre-update ones, as the slave sees them
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] wd, output logic [7:0] rd,
                      output logic er);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, mis};
    pwdata <= {24'h0, wd};
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) errors++;
    rd = prdata[7:0];
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    logic [7:0] d;
    logic r;
    xfer(1'b1, idx, wd, d, r);
  endtask

  task automatic rchk(input logic [7:0] idx, input logic [7:0] e);
    logic [7:0] d;
    logic r;
    xfer(1'b0, idx, 8'h00, d, r);
    `CHK(d, e)
  endtask

  // Pins need a few cycles at each level to be seen
  task automatic tgl(input int k);
    @(posedge ref_clk) pv[k] <= ~pv[k];
    repeat (3) @(posedge ref_clk);
  endtask

  task automatic fall(input int k);
    tgl(k);
    tgl(k);
  endtask

  task automatic ack(input int k);
    @(posedge ref_clk) ak[k] <= 1'b1;
    @(posedge ref_clk) ak[k] <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask

  task automatic t_regs;
    logic [7:0] d;
    logic r;
    rchk(8'h88, 8'h00);
    rchk(8'h89, 8'h00);
    rchk(8'hc1, 8'h00);
    rchk(8'hc8, 8'h00);
    wr(8'h89, 8'h55);
    rchk(8'h89, 8'h55);
    xfer(1'b0, 8'h00, 8'h00, d, r);
    `CHK({r, d}, 9'h100)
    mis = 2'b01;
    xfer(1'b1, 8'h88, 8'hff, d, r);
    mis = 2'b00;
    `CHK(r, 1'b1)
    rchk(8'h88, 8'h00);
    wr(8'h89, 8'h00);
  endtask

  task automatic t_mode16;
    wr(8'h89, 8'h05);
    wr(8'h8a, 8'hfe);
    wr(8'h8c, 8'hff);
    wr(8'h88, 8'h10);
    fall(0);
    rchk(8'h8a, 8'hff);
    fall(0);
    `CHK(ovf0, 1'b1)
    rchk(8'h8c, 8'h00);
    ack(0);
    `CHK(ovf0, 1'b0)
    wr(8'h88, 8'h00);
    fall(0);
    rchk(8'h8a, 8'h00);
  endtask

  task automatic t_mode13;
    wr(8'h89, 8'h04);
    wr(8'h8a, 8'h1f);
    wr(8'h88, 8'h10);
    fall(0);
    rchk(8'h8c, 8'h01);
    wr(8'h8a, 8'hff);
    fall(0);
    rchk(8'h8a, 8'he0);
    rchk(8'h8c, 8'h02);
    wr(8'h89, 8'h06);
    wr(8'h8c, 8'h80);
    wr(8'h8a, 8'hff);
    fall(0);
    rchk(8'h8a, 8'h80);
    `CHK(ovf0, 1'b1)
    wr(8'h88, 8'h00);
  endtask

  task automatic t_timer_one;
    wr(8'h89, 8'h70);
    wr(8'h8b, 8'hff);
    wr(8'h8d, 8'hff);
    wr(8'h88, 8'h40);
    fall(1);
    rchk(8'h8b, 8'hff);
    wr(8'h89, 8'h50);
    fall(1);
    `CHK(ovf1, 1'b1)
    rchk(8'h8d, 8'h00);
    ack(1);
    `CHK(ovf1, 1'b0)
    wr(8'h89, 8'hd0);
    @(posedge ref_clk) pv[5] <= 1'b0;
    fall(1);
    rchk(8'h8b, 8'h00);
    `CHK(pnd1, 1'b1)
    @(posedge ref_clk) pv[5] <= 1'b1;
    fall(1);
    rchk(8'h8b, 8'h01);
    ack(3);
    `CHK(pnd1, 1'b0)
    wr(8'h88, 8'h00);
  endtask

  task automatic t_split;
    wr(8'h89, 8'h07);
    wr(8'h8a, 8'h05);
    wr(8'h8c, 8'h33);
    wr(8'h88, 8'h10);
    fall(0);
    rchk(8'h8a, 8'h06);
    rchk(8'h8c, 8'h33);
    wr(8'h88, 8'h00);
  endtask

  task automatic t_ext_irq;
    wr(8'h88, 8'h01);
    tgl(4);
    `CHK(pnd0, 1'b1)
    ack(2);
    `CHK(pnd0, 1'b0)
    wr(8'h88, 8'h00);
    repeat (2) @(posedge ref_clk);
    `CHK(pnd0, 1'b1)
    tgl(4);
    ack(2);
    `CHK(pnd0, 1'b0)
  endtask

  task automatic t_timer_two;
    wr(8'hca, 8'h34);
    wr(8'hcb, 8'h12);
    wr(8'hcc, 8'hfe);
    wr(8'hcd, 8'hff);
    wr(8'hc8, 8'h12);
    fall(2);
    fall(2);
    rchk(8'hcc, 8'h34);
    rchk(8'hcd, 8'h12);
    wr(8'hc8, 8'h1a);
    wr(8'hcc, 8'h00);
    fall(3);
    rchk(8'hcc, 8'h34);
    wr(8'hc8, 8'h02);
    wr(8'hcc, 8'h00);
    fall(3);
    rchk(8'hcc, 8'h00);
    wr(8'hc8, 8'h00);
    fall(2);
    rchk(8'hcc, 8'h00);
  endtask

  // Timer two stopped at 0x1256 throughout
  task automatic t_capture;
    wr(8'hcc, 8'h56);
    wr(8'hc1, 8'hb4);
    @(posedge ref_clk) cap <= 4'h4;
    repeat (3) @(posedge ref_clk) cap <= 4'h0;
    rchk(8'hc2, 8'h56);
    rchk(8'hc3, 8'h12);
    wr(8'hc4, 8'haa);
    rchk(8'hc4, 8'h56);
    wr(8'hc6, 8'h56);
    wr(8'hc7, 8'h12);
    repeat (3) @(posedge ref_clk);
    `CHK(hit, 4'h8)
    rchk(8'hc7, 8'h12);
  endtask

  // Run windows of exactly 120 and 240 edges hold a whole number of ticks
  task automatic t_ticks;
    wr(8'h89, 8'h01);
    wr(8'h8a, 8'h00);
    wr(8'h8c, 8'h00);
    wr(8'h88, 8'h10);
    repeat (116) @(posedge ref_clk);
    wr(8'h88, 8'h00);
    rchk(8'h8a, 8'h0a);
    wr(8'hcc, 8'h00);
    wr(8'hcd, 8'h00);
    wr(8'hc8, 8'h81);
    repeat (236) @(posedge ref_clk);
    wr(8'hc8, 8'h00);
    rchk(8'hcc, 8'h0a);
  endtask

  task automatic t_irq_edges;
    int a;
    int b;
    wr(8'hc8, 8'h20);
    a = n2;
    b = n3;
    tgl(6);
    `CHK(n2, a)
    tgl(6);
    `CHK(n2, a + 1)
    tgl(7);
    `CHK(n3, b + 1)
    tgl(7);
    `CHK(n3, b + 1)
  endtask

  task automatic complete_run;
    if (errors == 0 && cmpCount > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    t_regs;
    t_mode16;
    t_mode13;
    t_timer_one;
    t_split;
    t_ext_irq;
    t_timer_two;
    t_capture;
    t_ticks;
    t_irq_edges;
    complete_run;
  end

  // Whole sequence needs under a thousand cycles
  initial begin
    repeat (40000) @(posedge ref_clk);
    errors++;
    complete_run;
  end
endmodule
